// >>> hw/wdtss_defs.svh
// Function
// R1: watchdog chain ticks from internal 31.25 kHz RC
// R2: reset loads watchdog control with 0x08
// R3: watchdog held cleared while crystal settle counts
// R4: 16-bit prescaler, code 0 is 1:32 doubling
// R5: scaler assign bit chains the postscaler after prescaler
// R6: always-on config bit ignores software enable
// R7: otherwise software enable bit turns watchdog on/off
// R8: wake with crystal clears scalers at settle end
// R9: two-speed runs on RC until primary stable
// R10: reset starts on RC, clock source forced 00
// R11: reset zeroes internal frequency select field
// R12: two-speed only for the three crystal modes
// R13: nonzero freq select wakes on block, stable flag
// R14: clock source writable before settle timeout
// R15: sleep aborts start-up, primary running stays clear
// R16: settle timer counts 1024 crystal cycles on RC
// R17: RC fall sets running, hold 8 crystal falls
// R18: software polls primary running bit for switchover
// R19: clock failure forces source 10, clears watchdog
// R20: sleep entry clears watchdog, keeps it running
// R21: clear instruction clears prescaler and postscaler
// R22: terminal count resets device, or wakes from sleep
`ifndef WDTSS_DEFS_SVH
`define WDTSS_DEFS_SVH

// =====================================================
// register map, byte address is four times the index
`define WDTSS_OPTION_IDX 10'h081
`define WDTSS_WDCTL_IDX 10'h105
`define WDTSS_OPTION_ADDR {`WDTSS_OPTION_IDX, 2'b00}
`define WDTSS_WDCTL_ADDR {`WDTSS_WDCTL_IDX, 2'b00}
`define WDTSS_OSC_ADDR 12'h040
`define WDTSS_CFG_ADDR 12'h044
`define WDTSS_CMD_ADDR 12'h048

// =====================================================
// reset values
`define WDTSS_WDCTL_RST 8'h08
`define WDTSS_OPTION_RST 8'h00
`define WDTSS_OSC_RST 8'h00
`define WDTSS_CFG_RST 8'h00

// =====================================================
// field positions
`define WDTSS_WD_SOFT_ON 0
`define WDTSS_WD_PRE_LO 1
`define WDTSS_WD_PRE_HI 4
`define WDTSS_OPT_PSA 3
`define WDTSS_OPT_PS_LO 0
`define WDTSS_OPT_PS_HI 2
`define WDTSS_OSC_SCS_LO 0
`define WDTSS_OSC_SCS_HI 1
`define WDTSS_OSC_INTERNAL_FREQ_STABLE 2
`define WDTSS_OSC_PRIMARY_CLOCK_RUNNING 3
`define WDTSS_OSC_INTERNAL_FREQ_SEL_LO 4
`define WDTSS_OSC_INTERNAL_FREQ_SEL_HI 6
`define WDTSS_CFG_ALWAYS_ON 0
`define WDTSS_CFG_TWO_SPEED 1
`define WDTSS_CFG_MODE_LO 2
`define WDTSS_CFG_MODE_HI 4
`define WDTSS_CMD_CLEAR 0
`define WDTSS_CMD_SLEEP 1
`define WDTSS_CMD_CLK_FAIL 2

// =====================================================
// encodings and counts
`define WDTSS_MODE_LP 3'h0
`define WDTSS_MODE_XT 3'h1
`define WDTSS_MODE_HS 3'h2
`define WDTSS_SCS_PRIMARY 2'h0
`define WDTSS_SCS_TIMER1 2'h1
`define WDTSS_SCS_FAIL 2'h2
`define WDTSS_SRC_PRIMARY 2'h0
`define WDTSS_SRC_TIMER1 2'h1
`define WDTSS_SRC_INTERNAL 2'h2
`define WDTSS_RC_KHZ_X100 3125
`define WDTSS_PRE_MAX_CODE 4'hb
`define WDTSS_PRE_BASE_SHIFT 5
`define WDTSS_SETTLE_COUNT 1024
`define WDTSS_HOLD_COUNT 8
`define WDTSS_RESP_OKAY 2'h0
`define WDTSS_RESP_SLVERR 2'h2

`endif

// >>> hw/wdtss_pkg.sv
package wdtss_pkg;
  // start-up sequencer states
  typedef enum logic [2:0] {
    SU_BOOT,
    SU_SETTLE,
    SU_WAIT_EDGE,
    SU_HOLD,
    SU_PRIMARY,
    SU_ALT,
    SU_SLEEP
  } wdtss_su_state_t;
endpackage : wdtss_pkg

// >>> hw/wdtss_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// three-flop pin synchroniser with edge pulses
module wdtss_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;
  wire agree = (s2 == s3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      // a change counts only once two stages agree
      if (agree) level <= s3;
      rise <= agree && s3 && !level;
      fall <= agree && !s3 && level;
    end
  end
endmodule : wdtss_pin_sync
`default_nettype wire

// >>> hw/wdtss_div.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// tick divider, done pulses after limit+1 ticks
module wdtss_div #(
  parameter int W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count;
  wire last = (count >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      done <= tick && last;
      if (tick) count <= last ? '0 : count + 1'b1;
    end
  end
endmodule : wdtss_div
`default_nettype wire

// >>> hw/wdtss_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdtss_defs.svh"
module wdtss_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic internal_rc_31k,
  input wire logic crystal_clk,
  input wire logic internal_osc_ready,
  input wire logic wake_req,
  output logic wdt_reset_req,
  output logic wdt_wake,
  output logic [1:0] sys_clk_src,
  output logic sys_clk_hold,
  output logic sleeping
);

  // =====================================================
  // registers and state
  logic [7:0] option_timer_cfg_reg;
  logic [7:0] watchdog_control_reg;
  logic [2:0] internal_freq_sel;
  logic [1:0] clock_source_sel;
  logic primary_clock_running;
  logic internal_freq_stable;
  logic [7:0] cfg_word;
  wdtss_pkg::wdtss_su_state_t state;
  wdtss_pkg::wdtss_su_state_t next_state;
  logic wake_settle;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // =====================================================
  // pin inputs
  logic rc_rise;
  logic rc_fall;
  logic xtal_fall;
  logic osc_ready;

  wdtss_pin_sync u_rc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(internal_rc_31k),
    .level(),
    .rise(rc_rise),
    .fall(rc_fall)
  );

  wdtss_pin_sync u_xtal_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(crystal_clk),
    .level(),
    .rise(),
    .fall(xtal_fall)
  );

  wdtss_pin_sync u_osc_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(internal_osc_ready),
    .level(osc_ready),
    .rise(),
    .fall()
  );

  // =====================================================
  // bus decode
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire lane0 = w_strb[0];
  wire wr_option = do_write && lane0 && (aw_addr == `WDTSS_OPTION_ADDR);
  wire wr_wdctl = do_write && lane0 && (aw_addr == `WDTSS_WDCTL_ADDR);
  wire wr_osc = do_write && lane0 && (aw_addr == `WDTSS_OSC_ADDR);
  wire wr_cfg = do_write && lane0 && (aw_addr == `WDTSS_CFG_ADDR);
  wire wr_cmd = do_write && lane0 && (aw_addr == `WDTSS_CMD_ADDR);
  wire wr_hit = (aw_addr == `WDTSS_OPTION_ADDR) ||
    (aw_addr == `WDTSS_WDCTL_ADDR) || (aw_addr == `WDTSS_OSC_ADDR) ||
    (aw_addr == `WDTSS_CFG_ADDR) || (aw_addr == `WDTSS_CMD_ADDR);
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_option = (s_axi_araddr == `WDTSS_OPTION_ADDR);
  wire rd_wdctl = (s_axi_araddr == `WDTSS_WDCTL_ADDR);
  wire rd_osc = (s_axi_araddr == `WDTSS_OSC_ADDR);
  wire rd_cfg = (s_axi_araddr == `WDTSS_CFG_ADDR);
  wire rd_cmd = (s_axi_araddr == `WDTSS_CMD_ADDR);
  wire rd_hit = rd_option || rd_wdctl || rd_osc || rd_cfg || rd_cmd;
  wire [7:0] osc_view = {1'b0, internal_freq_sel, primary_clock_running,
    internal_freq_stable, clock_source_sel};
  // command register is write-only, reads zero
  wire [7:0] rd_byte = rd_option ? option_timer_cfg_reg :
    rd_wdctl ? {3'h0, watchdog_control_reg[4:0]} :
    rd_osc ? osc_view :
    rd_cfg ? {3'h0, cfg_word[4:0]} : 8'h00;

  // =====================================================
  // commands and configuration
  wire cmd_clear = wr_cmd && w_data[`WDTSS_CMD_CLEAR];
  wire cmd_sleep = wr_cmd && w_data[`WDTSS_CMD_SLEEP];
  wire cmd_clk_fail = wr_cmd && w_data[`WDTSS_CMD_CLK_FAIL];
  wire [2:0] osc_mode = cfg_word[`WDTSS_CFG_MODE_HI:`WDTSS_CFG_MODE_LO];
  wire crystal_mode = (osc_mode == `WDTSS_MODE_LP) ||
    (osc_mode == `WDTSS_MODE_XT) || (osc_mode == `WDTSS_MODE_HS);
  wire two_speed = cfg_word[`WDTSS_CFG_TWO_SPEED] && crystal_mode; // R9 R12
  wire [1:0] next_scs_w = w_data[`WDTSS_OSC_SCS_HI:`WDTSS_OSC_SCS_LO];
  wire scs_write_alt = wr_osc && (next_scs_w != `WDTSS_SCS_PRIMARY);
  wire scs_write_pri = wr_osc && (next_scs_w == `WDTSS_SCS_PRIMARY);

  // =====================================================
  // watchdog chain
  logic settle_done;
  logic hold_done;
  logic pre_done;
  logic timeout;
  wire settling = (state == wdtss_pkg::SU_SETTLE);
  wire wdt_enable = cfg_word[`WDTSS_CFG_ALWAYS_ON] || // R6
    watchdog_control_reg[`WDTSS_WD_SOFT_ON]; // R7
  // the watchdog scalers stay cleared while the separate settle timer counts
  wire wdt_run = wdt_enable && !settling; // R3
  wire wdt_clear = cmd_clear || // R21
    cmd_sleep || // R20
    cmd_clk_fail || // R19
    timeout || (settle_done && wake_settle); // R8
  wire scaler_clear = wdt_clear || !wdt_run;
  wire [3:0] pre_code_raw =
    watchdog_control_reg[`WDTSS_WD_PRE_HI:`WDTSS_WD_PRE_LO];
  // codes above the top one behave as the top one
  wire [3:0] pre_code = (pre_code_raw > `WDTSS_PRE_MAX_CODE) ?
    `WDTSS_PRE_MAX_CODE : pre_code_raw;
  wire [4:0] pre_shift = 5'(pre_code) + 5'(`WDTSS_PRE_BASE_SHIFT);
  wire [16:0] pre_ratio = 17'h00001 << pre_shift;
  wire [15:0] pre_limit = 16'(pre_ratio - 17'h00001); // R4
  wire timer_scaler_assign = option_timer_cfg_reg[`WDTSS_OPT_PSA];
  wire [2:0] ps = option_timer_cfg_reg[`WDTSS_OPT_PS_HI:`WDTSS_OPT_PS_LO];
  wire [7:0] post_ratio = 8'h01 << ps;
  wire [6:0] post_limit = timer_scaler_assign ? 7'(post_ratio - 8'h01) : 7'h00; // R5

  wdtss_div #(.W(16)) u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(scaler_clear),
    .tick(rc_rise), // R1
    .limit(pre_limit),
    .done(pre_done)
  );

  wdtss_div #(.W(7)) u_postscale (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(scaler_clear),
    .tick(pre_done),
    .limit(post_limit),
    .done(timeout)
  );

  // =====================================================
  // start-up timers on crystal falling edges
  localparam logic [9:0] SETTLE_LAST = 10'(`WDTSS_SETTLE_COUNT - 1);
  localparam logic [2:0] HOLD_LAST = 3'(`WDTSS_HOLD_COUNT - 1);

  wdtss_div #(.W(10)) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(!settling),
    .tick(xtal_fall),
    .limit(SETTLE_LAST), // R16
    .done(settle_done)
  );

  wdtss_div #(.W(3)) u_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(state != wdtss_pkg::SU_HOLD),
    .tick(xtal_fall),
    .limit(HOLD_LAST), // R17
    .done(hold_done)
  );

  // =====================================================
  // start-up sequencer
  wire wake_now = sleeping && (wake_req || timeout); // R22
  wire [1:0] scs_now = clock_source_sel;

  always_comb begin
    next_state = state;
    case (state)
      wdtss_pkg::SU_BOOT: begin
        next_state = crystal_mode ? wdtss_pkg::SU_SETTLE :
          wdtss_pkg::SU_PRIMARY; // R10
      end
      wdtss_pkg::SU_SETTLE: begin
        if (settle_done) next_state = wdtss_pkg::SU_WAIT_EDGE;
      end
      wdtss_pkg::SU_WAIT_EDGE: begin
        if (rc_fall) next_state = wdtss_pkg::SU_HOLD; // R17
      end
      wdtss_pkg::SU_HOLD: begin
        if (hold_done) next_state = wdtss_pkg::SU_PRIMARY;
      end
      wdtss_pkg::SU_PRIMARY: begin
        next_state = state;
      end
      wdtss_pkg::SU_ALT: begin
        if (scs_write_pri) begin
          next_state = crystal_mode ? wdtss_pkg::SU_SETTLE :
            wdtss_pkg::SU_PRIMARY;
        end
      end
      wdtss_pkg::SU_SLEEP: begin
        if (wake_now) begin
          if (scs_now != `WDTSS_SCS_PRIMARY) next_state = wdtss_pkg::SU_ALT;
          else if (crystal_mode) next_state = wdtss_pkg::SU_SETTLE;
          else next_state = wdtss_pkg::SU_PRIMARY;
        end
      end
      default: next_state = wdtss_pkg::SU_BOOT;
    endcase
    if (state != wdtss_pkg::SU_SLEEP) begin
      // switching away before the settle timeout is allowed
      if (scs_write_alt || cmd_clk_fail) next_state = wdtss_pkg::SU_ALT; // R14
      if (cmd_sleep) next_state = wdtss_pkg::SU_SLEEP; // R15
    end
  end

  // =====================================================
  // clock selection, registered so outputs come from flops
  logic [1:0] next_src;
  logic next_hold;
  wire internal_osc_block_path = (internal_freq_sel != 3'h0);

  always_comb begin
    next_src = `WDTSS_SRC_INTERNAL;
    next_hold = 1'b0;
    case (next_state)
      wdtss_pkg::SU_SETTLE, wdtss_pkg::SU_WAIT_EDGE: begin
        // without two-speed nothing runs until the crystal is up
        next_hold = !two_speed; // R9
      end
      wdtss_pkg::SU_HOLD: next_hold = 1'b1; // R17
      wdtss_pkg::SU_PRIMARY: next_src = `WDTSS_SRC_PRIMARY;
      wdtss_pkg::SU_ALT: begin
        if (clock_source_sel == `WDTSS_SCS_TIMER1) begin
          next_src = `WDTSS_SRC_TIMER1;
        end
      end
      wdtss_pkg::SU_SLEEP: next_hold = 1'b1;
      default: next_hold = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= wdtss_pkg::SU_BOOT;
      sys_clk_src <= `WDTSS_SRC_INTERNAL;
      sys_clk_hold <= 1'b1;
      sleeping <= 1'b0;
      wake_settle <= 1'b0;
      wdt_reset_req <= 1'b0;
      wdt_wake <= 1'b0;
    end else begin
      state <= next_state;
      sys_clk_src <= next_src;
      sys_clk_hold <= next_hold;
      sleeping <= (next_state == wdtss_pkg::SU_SLEEP);
      if (wake_now) wake_settle <= 1'b1;
      else if (!settling) wake_settle <= 1'b0;
      wdt_reset_req <= timeout && !sleeping; // R22
      wdt_wake <= timeout && sleeping; // R22
    end
  end

  // =====================================================
  // oscillator control and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_freq_sel <= 3'h0; // R11
      clock_source_sel <= 2'h0; // R10
      primary_clock_running <= 1'b0;
      internal_freq_stable <= 1'b0;
    end else begin
      if (wr_osc) begin
        internal_freq_sel <=
          w_data[`WDTSS_OSC_INTERNAL_FREQ_SEL_HI:`WDTSS_OSC_INTERNAL_FREQ_SEL_LO];
        clock_source_sel <= next_scs_w; // R14
      end
      // a detected failure wins over a software write
      if (cmd_clk_fail) clock_source_sel <= `WDTSS_SCS_FAIL; // R19
      // set on the RC fall after settle, cleared when next state is neither hold nor primary
      if (state == wdtss_pkg::SU_WAIT_EDGE && next_state ==
          wdtss_pkg::SU_HOLD) begin
        primary_clock_running <= 1'b1; // R17
      end else if (next_state != wdtss_pkg::SU_HOLD &&
          next_state != wdtss_pkg::SU_PRIMARY) begin
        primary_clock_running <= 1'b0; // R15
      end
      if (wake_now || wr_osc || !internal_osc_block_path) begin
        internal_freq_stable <= 1'b0; // R13
      end else if (osc_ready) begin
        internal_freq_stable <= 1'b1; // R13
      end
    end
  end

  // =====================================================
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_control_reg <= `WDTSS_WDCTL_RST; // R2
      option_timer_cfg_reg <= `WDTSS_OPTION_RST;
      cfg_word <= `WDTSS_CFG_RST;
    end else begin
      if (wr_wdctl) watchdog_control_reg <= {3'h0, w_data[4:0]};
      if (wr_option) option_timer_cfg_reg <= w_data[7:0];
      if (wr_cfg) cfg_word <= {3'h0, w_data[4:0]};
    end
  end

  // =====================================================
  // axi4-lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDTSS_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held;
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `WDTSS_RESP_OKAY : `WDTSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // =====================================================
  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `WDTSS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte}; // R18
        s_axi_rresp <= rd_hit ? `WDTSS_RESP_OKAY : `WDTSS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : wdtss_top
`default_nettype wire

// >>> testbench/wdtss_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// start-up and bus checks on the top ports
module wdtss_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic wdt_reset_req,
  input wire logic wdt_wake,
  input wire logic [1:0] sys_clk_src,
  input wire logic sys_clk_hold,
  input wire logic sleeping
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_src_after_reset:
    assert property ($rose(aresetn) |-> sys_clk_src == 2'h2 && sys_clk_hold)
    else $error("clock source not internal after reset");
  chk_settle_quiet:
    assert property ($rose(aresetn) |-> !wdt_reset_req [*8])
    else $error("watchdog fired during settle");
  // switch to primary only when hold was set one cycle and eight cycles before
  chk_switch_after_hold:
    assert property (sys_clk_src == 2'h0 && $past(sys_clk_src) != 2'h0
      |-> $past(sys_clk_hold) && $past(sys_clk_hold, 8))
    else $error("primary selected without hold");
  chk_sleep_holds:
    assert property (sleeping |-> sys_clk_hold)
    else $error("clock not held in sleep");
  chk_wake_asleep:
    assert property (wdt_wake |-> $past(sleeping) && !wdt_reset_req)
    else $error("wake pulse while awake");
  chk_reset_awake:
    assert property (wdt_reset_req |-> !$past(sleeping) ##1 !wdt_reset_req)
    else $error("reset request wrong or too long");
  chk_bvalid_stands:
    assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rvalid_stands:
    assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("reserved read bits set");
endmodule : wdtss_sva
bind wdtss_top wdtss_sva i_sva (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .wdt_reset_req(wdt_reset_req),
  .wdt_wake(wdt_wake),
  .sys_clk_src(sys_clk_src),
  .sys_clk_hold(sys_clk_hold),
  .sleeping(sleeping)
);
`default_nettype wire

// >>> testbench/watchdog_with_two_speed_startup_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdtss_defs.svh"
module watchdog_with_two_speed_startup_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic internal_rc_31k = 1'b0;
  logic crystal_clk = 1'b0;
  logic rc_run = 1'b1;
  logic osc_rdy = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sys_clk_src, last_resp;
  logic [31:0] s_axi_rdata, last_data;
  logic wdt_reset_req, wdt_wake, sys_clk_hold, sleeping;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int rises = 0;
  int xt_div = 0;
  int rc_div = 0;

  always #50 aclk = ~aclk;

  wdtss_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .internal_rc_31k(internal_rc_31k),
    .crystal_clk(crystal_clk), .internal_osc_ready(osc_rdy),
    .wake_req(1'b0), .wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake),
    .sys_clk_src(sys_clk_src), .sys_clk_hold(sys_clk_hold),
    .sleeping(sleeping)
  );

  // ==========================================
  // slow pins: crystal half period 5, rc half period 8 cycles
  always @(posedge aclk) begin
    xt_div <= (xt_div == 4) ? 0 : xt_div + 1;
    if (xt_div == 4) crystal_clk <= ~crystal_clk;
    rc_div <= (rc_div == 7 || !rc_run) ? 0 : rc_div + 1;
    if (!rc_run) internal_rc_31k <= 1'b0;
    else if (rc_div == 7) begin
      internal_rc_31k <= ~internal_rc_31k;
      if (!internal_rc_31k) rises <= rises + 1;
    end
  end

  // ==========================================
  // reporting
  task final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      final_report;
    end
  end

  task check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // ==========================================
  // bus tasks; response ready offered along with the request
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    last_resp = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    last_data = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask : axi_rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    axi_rd(a);
    check("read data", exp, last_data);
    check("read response", {30'h0, er}, {30'h0, last_resp});
  endtask : rd_chk

  task automatic wait_src(input logic [1:0] v);
    while (sys_clk_src !== v) @(posedge aclk);
  endtask : wait_src

  // rc stopped while configuring, so every tick is counted
  task automatic wd_trial(input logic [7:0] opt, wd, cfg, input int pre,
                          input logic [7:0] cmd, input int exp,
                          input logic wake);
    int base;
    rc_run <= 1'b0;
    axi_wr(`WDTSS_OPTION_ADDR, opt);
    axi_wr(`WDTSS_CFG_ADDR, cfg);
    axi_wr(`WDTSS_WDCTL_ADDR, wd);
    if (pre > 0) begin
      // rises has one driver, so count from a snapshot
      base = rises;
      @(posedge aclk);
      rc_run <= 1'b1;
      while (rises - base < pre) @(posedge aclk);
      rc_run <= 1'b0;
      axi_wr(`WDTSS_CMD_ADDR, cmd);
    end
    repeat (8) @(posedge aclk);
    base = rises;
    @(posedge aclk);
    rc_run <= 1'b1;
    do @(posedge aclk);
    while (wdt_reset_req !== 1'b1 && wdt_wake !== 1'b1 &&
           rises - base < exp + 40);
    check("timeout rises", exp,
          (wdt_reset_req === 1'b1 || wdt_wake === 1'b1) ? rises - base : 0);
    check("wake pulse", {31'h0, wake}, {31'h0, wdt_wake});
  endtask : wd_trial

  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check("hold in settle", 1, {31'h0, sys_clk_hold});
    rd_chk(`WDTSS_WDCTL_ADDR, 32'h08, 2'h0);
    rd_chk(`WDTSS_OPTION_ADDR, 32'h00, 2'h0);
    rd_chk(`WDTSS_OSC_ADDR, 32'h00, 2'h0);
    rd_chk(12'h100, 32'h0, `WDTSS_RESP_SLVERR);
    axi_wr(`WDTSS_CFG_ADDR, 8'h02);
    wait_src(2'h0);
    rd_chk(`WDTSS_OSC_ADDR, 32'h08, 2'h0);
    wd_trial(8'h00, 8'h01, 8'h02, 0, 8'h00, 32, 1'b0);
    wd_trial(8'h00, 8'h03, 8'h02, 0, 8'h00, 64, 1'b0);
    wd_trial(8'h0a, 8'h01, 8'h02, 0, 8'h00, 128, 1'b0);
    wd_trial(8'h00, 8'h00, 8'h02, 0, 8'h00, 0, 1'b0);
    wd_trial(8'h00, 8'h00, 8'h03, 0, 8'h00, 32, 1'b0);
    wd_trial(8'h00, 8'h01, 8'h02, 20, 8'h01, 32, 1'b0);
    wd_trial(8'h00, 8'h01, 8'h02, 10, 8'h02, 32, 1'b1);
    rc_run <= 1'b1;
    rd_chk(`WDTSS_OSC_ADDR, 32'h00, 2'h0);
    check("source after wake", 2, {30'h0, sys_clk_src});
    wait_src(2'h0);
    rd_chk(`WDTSS_OSC_ADDR, 32'h08, 2'h0);
    axi_wr(`WDTSS_OSC_ADDR, 8'h10);
    repeat (10) @(posedge aclk);
    rd_chk(`WDTSS_OSC_ADDR, 32'h18, 2'h0);
    osc_rdy <= 1'b1;
    repeat (10) @(posedge aclk);
    rd_chk(`WDTSS_OSC_ADDR, 32'h1c, 2'h0);
    axi_wr(`WDTSS_CMD_ADDR, 8'h04);
    axi_rd(`WDTSS_OSC_ADDR);
    check("forced source", 2, {30'h0, last_data[1:0]});
    check("source after fail", 2, {30'h0, sys_clk_src});
    axi_wr(`WDTSS_OSC_ADDR, 8'h01);
    @(posedge aclk);
    check("timer1 source", 1, {30'h0, sys_clk_src});
    final_report;
  end
endmodule : watchdog_with_two_speed_startup_test
`default_nettype wire
